// ---- shared/sfc_pkg.sv ----
package sfc_pkg;

  // ==========================================================================
  // opcodes
  localparam logic [7:0] OP_WREN      = 8'h06;
  localparam logic [7:0] OP_VWREN     = 8'h50;
  localparam logic [7:0] OP_WRDI      = 8'h04;
  localparam logic [7:0] OP_RDSR1     = 8'h05;
  localparam logic [7:0] OP_RDSR2     = 8'h35;
  localparam logic [7:0] OP_WRSR      = 8'h01;
  localparam logic [7:0] OP_RPD_ID    = 8'hAB;
  localparam logic [7:0] OP_ID_DUAL   = 8'h92;
  localparam logic [7:0] OP_ID_QUAD   = 8'h94;
  localparam logic [7:0] OP_SEC_ERASE = 8'h44;
  localparam logic [7:0] OP_SEC_PROG  = 8'h42;
  localparam logic [7:0] OP_SEC_READ  = 8'h48;
  localparam logic [7:0] OP_QREAD     = 8'hEB;
  localparam logic [7:0] OP_WREAD     = 8'hE7;
  localparam logic [7:0] OP_OREAD     = 8'hE3;

  // ==========================================================================
  // apb register map (byte addresses)
  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_ADDR   = 8'h04;
  localparam logic [7:0] REG_WDATA  = 8'h08;
  localparam logic [7:0] REG_RDATA  = 8'h0C;
  localparam logic [7:0] REG_STATUS = 8'h10;

  // ctrl fields
  localparam int CTRL_OP_LSB   = 0;
  localparam int CTRL_WLEN_LSB = 8;
  localparam int CTRL_RLEN_LSB = 12;
  localparam int CTRL_START    = 16;

  // ==========================================================================
  // status register bit positions (16-bit view)
  localparam int SR_BUSY = 0;
  localparam int SR_WEL  = 1;

  // timing
  localparam int SCK_HALF_CYC = 2;
  localparam int DIV_W        = 2;

  localparam logic [31:0] RESET_WORD = 32'h0000_0000;

  // bus modes
  typedef enum logic [1:0] {
    SFC_MODE_SINGLE = 2'b00,
    SFC_MODE_DUAL   = 2'b01,
    SFC_MODE_QUAD   = 2'b10
  } sfc_mode_t;

  typedef struct packed {
    logic       cs_n;
    logic       sck;
    logic [3:0] io_o;
    logic [3:0] io_oe;
  } sfc_pins_t;

endpackage

// ---- rtl/sfc_clkdiv.sv ----
`timescale 1ns/10ps
module sfc_clkdiv #(
  parameter int HALF = 2
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run,
  output logic      tick
);
  logic [sfc_pkg::DIV_W-1:0] cnt_q;

  // one-cycle enable every HALF pclk cycles while a frame runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else if (!run) begin
      cnt_q <= '0;
      tick  <= 1'b0;
    end else if (cnt_q == sfc_pkg::DIV_W'(HALF - 1)) begin
      cnt_q <= '0;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      tick  <= 1'b0;
    end
  end
endmodule

// ---- rtl/sfc_host.sv ----
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/10ps
module sfc_host (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             flash_cs_n,
  output logic             flash_sck,
  output logic [3:0]       flash_io_o,
  output logic [3:0]       flash_io_oe,
  input  wire logic [3:0]  flash_io_i
);
  typedef enum logic [2:0] {
    SFC_IDLE  = 3'b000,
    SFC_SHIFT = 3'b001,
    SFC_GAP   = 3'b010,
    SFC_DONE  = 3'b011
  } sfc_state_t;

  // ==========================================================================
  // software registers
  logic [31:0] ctrl_q;
  logic [31:0] addr_q;
  logic [31:0] wdata_q;
  logic [31:0] rdata_q;
  logic        busy_q;
  logic        done_q;
  logic        refused_q;
  logic        wel_shadow_q;
  logic        varm_q;

  logic        apb_wr;
  logic        apb_rd;
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !penable && !pwrite;

  // ==========================================================================
  // frame description derived from the opcode
  logic [7:0]  op;
  logic [3:0]  wlen;
  logic [3:0]  rlen;
  assign op   = ctrl_q[sfc_pkg::CTRL_OP_LSB +: 8];
  assign wlen = ctrl_q[sfc_pkg::CTRL_WLEN_LSB +: 4];
  assign rlen = ctrl_q[sfc_pkg::CTRL_RLEN_LSB +: 4];

  logic [1:0]  lanes_in;
  logic [1:0]  lanes_out;
  logic [3:0]  addr_bytes;
  logic [3:0]  dummy_clk;
  logic        needs_wel;
  logic        addr_ok;

  always_comb begin
    lanes_in   = 2'd0;
    lanes_out  = 2'd0;
    addr_bytes = 4'd0;
    dummy_clk  = 4'd0;
    needs_wel  = 1'b0;
    addr_ok    = 1'b1;
    case (op)
      sfc_pkg::OP_RPD_ID: begin
        addr_bytes = 4'd3;
      end
      sfc_pkg::OP_ID_DUAL: begin
        lanes_in = 2'd1; lanes_out = 2'd1; addr_bytes = 4'd4;
      end
      sfc_pkg::OP_ID_QUAD: begin
        lanes_in = 2'd2; lanes_out = 2'd2; addr_bytes = 4'd4; dummy_clk = 4'd4;
      end
      sfc_pkg::OP_QREAD: begin
        lanes_in = 2'd2; lanes_out = 2'd2; addr_bytes = 4'd4; dummy_clk = 4'd4;
      end
      sfc_pkg::OP_WREAD: begin
        lanes_in = 2'd2; lanes_out = 2'd2; addr_bytes = 4'd4; dummy_clk = 4'd2;
        addr_ok  = (addr_q[0] == 1'b0);
      end
      sfc_pkg::OP_OREAD: begin
        lanes_in = 2'd2; lanes_out = 2'd2; addr_bytes = 4'd4;
        addr_ok  = (addr_q[3:0] == 4'h0);
      end
      sfc_pkg::OP_SEC_ERASE, sfc_pkg::OP_SEC_PROG: begin
        addr_bytes = 4'd3; needs_wel = 1'b1;
        addr_ok = (addr_q[23:16] == 8'h00) && (addr_q[11:8] == 4'h0);
      end
      sfc_pkg::OP_SEC_READ: begin
        addr_bytes = 4'd4; // trailing dummy byte
        addr_ok = (addr_q[23:16] == 8'h00) && (addr_q[11:8] == 4'h0);
      end
      sfc_pkg::OP_WRSR: begin
        needs_wel = !varm_q;
        addr_ok   = (wlen == 4'd1) || (wlen == 4'd2);
      end
      default: begin
      end
    endcase
  end

  // status read is always allowed; others are refused while busy is set
  logic        is_sr_read;
  logic        accept;
  assign is_sr_read = (op == sfc_pkg::OP_RDSR1) || (op == sfc_pkg::OP_RDSR2);
  assign accept = addr_ok && (!needs_wel || wel_shadow_q) &&
                  (is_sr_read || !busy_q);

  // ==========================================================================
  // shift engine
  sfc_state_t  state_q;
  logic        tick;
  logic        run;
  logic [63:0] tx_q;
  logic [7:0]  nclk_q;
  logic [7:0]  rx_clk_q;
  logic [31:0] rx_q;
  logic [1:0]  mode_q;
  logic [7:0]  op_clk_q;
  logic [3:0]  sync1_q;
  logic [3:0]  sync2_q;
  logic        cs_q;
  logic        sck_q;
  logic [3:0]  io_q;
  logic [3:0]  oe_q;

  assign run = (state_q == SFC_SHIFT);

  sfc_clkdiv #(
    .HALF (sfc_pkg::SCK_HALF_CYC)
  ) u_div (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (run),
    .tick    (tick)
  );

  // two-flop input synchroniser
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= flash_io_i;
      sync2_q <= sync1_q;
    end
  end

  // total clocks: opcode 8, address/mode/wdata per lane width, dummies, reads
  logic [7:0] out_clks;
  logic [7:0] in_bits;
  logic [7:0] tot_clks;
  always_comb begin
    in_bits  = {addr_bytes, 3'b000} + {1'b0, wlen, 3'b000};
    out_clks = {rlen, 3'b000} >> lanes_out;
    tot_clks = 8'd8 + (in_bits >> lanes_in) + {4'd0, dummy_clk} + out_clks;
  end

  // address bytes go out msb first, left-justified after the opcode
  logic [63:0] tx_init;
  always_comb begin
    tx_init = {addr_q, wdata_q} << ((4'd4 - addr_bytes) * 8);
    if (addr_bytes == 4'd0) begin
      tx_init = {wdata_q, 32'h0};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q  <= SFC_IDLE;
      cs_q     <= 1'b1;
      sck_q    <= 1'b0;
      io_q     <= 4'h0;
      oe_q     <= 4'h0;
      tx_q     <= 64'h0;
      nclk_q   <= 8'h0;
      op_clk_q <= 8'h0;
      rx_q     <= 32'h0;
      rx_clk_q <= 8'h0;
      mode_q   <= 2'd0;
      done_q   <= 1'b0;
      refused_q <= 1'b0;
    end else begin
      case (state_q)
        SFC_IDLE: begin
          if (apb_wr && paddr == sfc_pkg::REG_CTRL && pwdata[sfc_pkg::CTRL_START]) begin
            state_q <= SFC_GAP;
            done_q  <= 1'b0;
          end
        end
        SFC_GAP: begin
          if (accept) begin
            state_q  <= SFC_SHIFT;
            cs_q     <= 1'b0;
            tx_q     <= tx_init;
            nclk_q   <= tot_clks;
            op_clk_q <= 8'd8;
            rx_clk_q <= out_clks;
            rx_q     <= 32'h0;
            mode_q   <= 2'd0;
            io_q     <= {3'b000, op[7]};
            oe_q     <= 4'b0001;
            refused_q <= 1'b0;
          end else begin
            state_q   <= SFC_DONE;
            refused_q <= 1'b1;
          end
        end
        SFC_SHIFT: begin
          if (tick) begin
            sck_q <= !sck_q;
            if (sck_q) begin
              // sample here, not at the rise: the synchroniser adds two cycles
              if (oe_q == 4'h0 && nclk_q <= rx_clk_q && rx_clk_q != 8'd0) begin
                case (lanes_out)
                  2'd1: rx_q <= {rx_q[29:0], sync2_q[1], sync2_q[0]};
                  2'd2: rx_q <= {rx_q[27:0], sync2_q};
                  default: rx_q <= {rx_q[30:0], sync2_q[1]};
                endcase
              end
              // falling edge: advance outputs
              nclk_q <= nclk_q - 8'd1;
              if (nclk_q == 8'd1) begin
                state_q <= SFC_DONE; // frame ends after tot_clks clocks, a byte multiple only if dummies and lanes allow
                cs_q    <= 1'b1;
                oe_q    <= 4'h0;
              end else if (op_clk_q > 8'd1) begin
                op_clk_q <= op_clk_q - 8'd1;
                io_q     <= {3'b000, op[3'(op_clk_q - 8'd2)]};
              end else if (nclk_q > {1'b0, out_clks} + {4'd0, dummy_clk} + 8'd1) begin
                op_clk_q <= 8'd0;
                case (lanes_in)
                  2'd1: begin
                    io_q <= {2'b00, tx_q[63], tx_q[62]};
                    tx_q <= {tx_q[61:0], 2'b00};
                    oe_q <= 4'b0011;
                  end
                  2'd2: begin
                    io_q <= tx_q[63:60];
                    tx_q <= {tx_q[59:0], 4'h0};
                    oe_q <= 4'b1111;
                  end
                  default: begin
                    io_q <= {3'b000, tx_q[63]};
                    tx_q <= {tx_q[62:0], 1'b0};
                    oe_q <= 4'b0001;
                  end
                endcase
              end else begin
                op_clk_q <= 8'd0;
                oe_q     <= 4'h0; // release lanes for dummies and data
              end
            end
          end
        end
        SFC_DONE: begin
          sck_q   <= 1'b0;
          done_q  <= 1'b1;
          state_q <= SFC_IDLE;
        end
        default: state_q <= SFC_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // tracked device write state, used to refuse writes early
  logic frame_end;
  assign frame_end = (state_q == SFC_DONE) && !refused_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wel_shadow_q <= 1'b0;
      varm_q       <= 1'b0;
    end else if (frame_end) begin
      case (op)
        sfc_pkg::OP_WREN:  wel_shadow_q <= 1'b1;
        sfc_pkg::OP_VWREN: varm_q <= 1'b1;
        sfc_pkg::OP_WRDI: begin
          wel_shadow_q <= 1'b0;
          varm_q       <= 1'b0;
        end
        sfc_pkg::OP_WRSR, sfc_pkg::OP_SEC_ERASE, sfc_pkg::OP_SEC_PROG: begin
          wel_shadow_q <= 1'b0;
          varm_q       <= 1'b0;
        end
        sfc_pkg::OP_RDSR1: wel_shadow_q <= rx_q[sfc_pkg::SR_WEL];
        default: begin
        end
      endcase
    end
  end

  // busy follows the last status-1 read and is set by a non-volatile status write; software polls until clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
    end else if (frame_end && op == sfc_pkg::OP_RDSR1) begin
      busy_q <= rx_q[sfc_pkg::SR_BUSY];
    end else if (frame_end && op == sfc_pkg::OP_WRSR && !varm_q) begin
      busy_q <= 1'b1;
    end
  end

  // write data mask: bits 1..0 and 15 are cleared only if ctrl already holds OP_WRSR when wdata is written
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q  <= sfc_pkg::RESET_WORD;
      addr_q  <= sfc_pkg::RESET_WORD;
      wdata_q <= sfc_pkg::RESET_WORD;
    end else if (apb_wr && state_q == SFC_IDLE) begin
      case (paddr)
        sfc_pkg::REG_CTRL:  ctrl_q  <= {15'h0, 1'b0, pwdata[15:0]};
        sfc_pkg::REG_ADDR:  addr_q  <= pwdata;
        sfc_pkg::REG_WDATA: wdata_q <= (ctrl_q[7:0] == sfc_pkg::OP_WRSR) ?
                                       {pwdata[31:24] & 8'hFC, pwdata[23:16] & 8'h7F,
                                        pwdata[15:0]} : pwdata;
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= 32'h0;
    end else if (state_q == SFC_DONE) begin
      rdata_q <= rx_q;
    end
  end

  // ==========================================================================
  // apb read path, no wait states
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= 1'b0;
      if (apb_rd) begin
        case (paddr)
          sfc_pkg::REG_CTRL:   prdata <= ctrl_q;
          sfc_pkg::REG_ADDR:   prdata <= addr_q;
          sfc_pkg::REG_WDATA:  prdata <= wdata_q;
          sfc_pkg::REG_RDATA:  prdata <= rdata_q;
          sfc_pkg::REG_STATUS: prdata <= {26'h0, varm_q, wel_shadow_q, busy_q,
                                          refused_q, done_q, (state_q != SFC_IDLE)};
          default: begin
            prdata  <= 32'h0;
            pslverr <= 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flash_cs_n  <= 1'b1;
      flash_sck   <= 1'b0;
      flash_io_o  <= 4'h0;
      flash_io_oe <= 4'h0;
    end else begin
      flash_cs_n  <= cs_q;
      flash_sck   <= sck_q;
      flash_io_o  <= io_q;
      flash_io_oe <= oe_q;
    end
  end
endmodule

// ---- test/sfc_flash_model.sv ----
`timescale 1ns/10ps
module sfc_flash_model #(
  parameter logic [7:0] PART_CODE = 8'h5C, // arbitrary value
  parameter int         BUSY_NS   = 3000
) (
  input  wire logic       cs_n,
  input  wire logic       sck,
  input  wire logic       pwr_n,
  input  wire logic [3:0] din,
  output logic [3:0]      dq,
  output logic [3:0]      dq_oe
);
  logic [7:0] nv1, nv2, v1, v2, op, sh, b1, b2, ob;
  logic       write_enable_latch, varm, busy;
  int         n;
  initial begin
    nv1 = 8'h00;
    nv2 = 8'h00;
    dq = 4'h0;
    dq_oe = 4'h0;
  end
  // ==========================================================================
  // power-up: volatile copies reload
  always @(posedge pwr_n) begin
    v1 = nv1;
    v2 = nv2;
    write_enable_latch = 1'b0;
    varm = 1'b0;
    busy = 1'b0;
  end
  always @(negedge cs_n) begin
    n = 0;
    op = 8'h00;
  end
  always @(posedge sck) if (!cs_n) begin
    sh = {sh[6:0], din[0]};
    n = n + 1;
    if (n == 8) op = sh;
    if (n == 16) b1 = sh;
    if (n == 24) b2 = sh;
  end
  // read data on falling edges, repeating until cs rises
  always @(negedge sck) if (!cs_n) begin
    ob = (op == sfc_pkg::OP_RPD_ID) ? PART_CODE :
         (op == sfc_pkg::OP_RDSR2) ? v2 : {v1[7:2], write_enable_latch, busy};
    dq_oe[1] = (n >= 8 && (op == sfc_pkg::OP_RDSR1 || op == sfc_pkg::OP_RDSR2)) ||
               (n >= 32 && op == sfc_pkg::OP_RPD_ID);
    dq[1] = ob[7 - (n % 8)];
  end
  // ==========================================================================
  // execution at cs rise; busy blocks all but status and part-code reads
  always @(posedge cs_n) begin
    dq_oe = 4'h0;
    if (!busy && n % 8 == 0) begin
      case (op)
        sfc_pkg::OP_WREN: write_enable_latch = 1'b1;
        sfc_pkg::OP_VWREN: varm = 1'b1;
        sfc_pkg::OP_WRDI: begin
          write_enable_latch = 1'b0;
          varm = 1'b0;
        end
        sfc_pkg::OP_WRSR: if ((n == 16 || n == 24) && (varm || write_enable_latch)) begin
          v1[7:2] = b1[7:2];
          v2 = (n == 16) ? (v2 & 8'hBC) :
               {v2[7], b2[6], b2[5:2] | v2[5:2], b2[1], b2[0] | (varm & v2[0])};
          if (!varm) begin
            nv1 = v1;
            nv2 = v2;
            busy = 1'b1;
            write_enable_latch <= #(BUSY_NS) 1'b0;
            busy <= #(BUSY_NS) 1'b0;
          end
          varm = 1'b0;
        end
        default: ;
      endcase
    end
  end
endmodule

// ---- test/sfc_host_sva.sv ----
`timescale 1ns/10ps
module sfc_host_sva (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        flash_cs_n,
  input wire logic        flash_sck,
  input wire logic [3:0]  flash_io_o,
  input wire logic [3:0]  flash_io_oe,
  input wire logic [3:0]  flash_io_i
);
  // ==========================================================================
  // frame tracking: rising sck count and captured opcode
  logic       sck_q, rise, rd_acc, mapped;
  logic [8:0] cnt_q;
  logic [7:0] op_q;
  assign rise = flash_sck && !sck_q;
  assign rd_acc = psel && penable && pready && !pwrite;
  assign mapped = paddr inside {sfc_pkg::REG_CTRL, sfc_pkg::REG_ADDR, sfc_pkg::REG_WDATA,
                                sfc_pkg::REG_RDATA, sfc_pkg::REG_STATUS};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sck_q <= 1'b0;
    else sck_q <= flash_sck;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_q <= 9'h000;
    else if (flash_cs_n) cnt_q <= 9'h000;
    else if (rise) cnt_q <= cnt_q + 9'h001;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) op_q <= 8'h00;
    else if (rise && cnt_q < 9'h008) op_q <= {op_q[6:0], flash_io_o[0]};
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================================================
  // assertions
  chk_sck_idle_low:
    assert property (flash_cs_n |-> !flash_sck) else $error("sck high outside frame");
  chk_ready_after_setup:
    assert property (psel && !penable |=> pready) else $error("pready late");
  chk_ready_in_access:
    assert property (pready |-> psel && penable) else $error("pready outside access");
  chk_unmapped_err:
    assert property (rd_acc && !mapped |-> pslverr) else $error("no pslverr");
  chk_mapped_ok:
    assert property (rd_acc && mapped |-> !pslverr) else $error("stray pslverr");
  chk_sck_half_period:
    assert property ($rose(flash_sck) |=> flash_sck ##1 !flash_sck) else $error("sck period");
  chk_lane_hold:
    assert property ($rose(flash_sck) |=> $stable(flash_io_o)) else $error("lane moved");
  chk_byte_frame:
    assert property ($rose(flash_cs_n) |-> cnt_q[2:0] == 3'h0) else $error("partial byte");
  chk_status_wr_len:
    assert property ($rose(flash_cs_n) && op_q == sfc_pkg::OP_WRSR |->
                     cnt_q == 9'd16 || cnt_q == 9'd24) else $error("bad write length");
  cov_status_write: cover property ($rose(flash_cs_n) && op_q == sfc_pkg::OP_WRSR);
  cov_part_code: cover property ($rose(flash_cs_n) && op_q == sfc_pkg::OP_RPD_ID);
  cov_unmapped: cover property (rd_acc && pslverr);
endmodule

bind sfc_host sfc_host_sva sfc_host_sva_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .flash_cs_n(flash_cs_n), .flash_sck(flash_sck), .flash_io_o(flash_io_o),
  .flash_io_oe(flash_io_oe), .flash_io_i(flash_io_i)
);

// ---- test/sfc_host_test.sv ----
`timescale 1ns/10ps
module sfc_host_test;
  localparam logic [7:0] PART = 8'h5C; // arbitrary value
  logic        pclk, presetn, psel, penable, pwrite, pwr_n, pready, pslverr, last_err;
  logic        flash_cs_n, flash_sck;
  logic        junk = 1'b0;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, r, st, v, w;
  logic [3:0]  flash_io_o, flash_io_oe, flash_io_i, m_o, m_oe;
  logic [31:0] exp_q[$];
  int          fails = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  int          seed;
  sfc_host sfc_host_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_cs_n(flash_cs_n), .flash_sck(flash_sck), .flash_io_o(flash_io_o),
    .flash_io_oe(flash_io_oe), .flash_io_i(flash_io_i)
  );
  sfc_flash_model #(.PART_CODE(PART)) sfc_flash_model_i (
    .cs_n(flash_cs_n), .sck(flash_sck), .pwr_n(pwr_n), .din(flash_io_i), .dq(m_o), .dq_oe(m_oe)
  );
  // released lanes show a toggling level, never a stale value
  assign flash_io_i = (flash_io_oe & flash_io_o) | (~flash_io_oe & m_oe & m_o) |
                      (~flash_io_oe & ~m_oe & {4{junk}});
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  // ==========================================================================
  // checking and closing
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR at %0t: seen %08h expected %08h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge pclk) begin
    junk <= ~junk;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      wrap_up;
    end
  end
  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1 && !pwrite && paddr == sfc_pkg::REG_RDATA &&
        exp_q.size() > 0) begin
      check(prdata & 32'h0000_FFFF, exp_q.pop_front());
    end
  end
  // ==========================================================================
  // apb master and frame helpers
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic run(input logic [7:0] op, input logic [3:0] wl, input logic [3:0] rl);
    apb(1'b1, sfc_pkg::REG_CTRL, {15'h0000, 1'b1, rl, wl, op});
    do apb(1'b0, sfc_pkg::REG_STATUS, 32'h0000_0000); while (r[0] || !(r[1] || r[2]));
    st = r;
  endtask
  task automatic rd(input logic [7:0] op, input logic [7:0] e, input logic note);
    run(op, 4'h0, 4'h2);
    if (note) exp_q.push_back({16'h0000, e, e});
    apb(1'b0, sfc_pkg::REG_RDATA, 32'h0000_0000);
  endtask
  task automatic wrs(input logic [7:0] en, input logic [7:0] d);
    run(en, 4'h0, 4'h0);
    apb(1'b1, sfc_pkg::REG_WDATA, {d, 24'h000000});
    run(sfc_pkg::OP_WRSR, 4'h1, 4'h0);
  endtask
  task automatic tend(input int n);
    $display("test %0d done", n);
  endtask
  // ==========================================================================
  // main sequence
  initial begin
    seed = 32'h6A8AFE3F;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 1'b0;
    pwr_n = 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    pwr_n <= 1'b1;
    @(posedge pclk);
    v = $random(seed);
    w = $random(seed);
    rd(sfc_pkg::OP_RDSR1, 8'h00, 1'b1);
    rd(sfc_pkg::OP_RDSR2, 8'h00, 1'b1);
    tend(1);
    run(sfc_pkg::OP_WREN, 4'h0, 4'h0);
    rd(sfc_pkg::OP_RDSR1, 8'h02, 1'b1);
    run(sfc_pkg::OP_WRDI, 4'h0, 4'h0);
    rd(sfc_pkg::OP_RDSR1, 8'h00, 1'b1);
    tend(2);
    apb(1'b1, sfc_pkg::REG_WDATA, w);
    run(sfc_pkg::OP_WRSR, 4'h1, 4'h0);
    check({31'h0, st[2]}, 32'h1);
    tend(3);
    wrs(sfc_pkg::OP_WREN, v[7:0]);
    rd(sfc_pkg::OP_RDSR1, {v[7:2], 2'b11}, 1'b1); // busy and latch seen mid-cycle
    run(sfc_pkg::OP_WREN, 4'h0, 4'h0);
    check({31'h0, st[2]}, 32'h1);
    do rd(sfc_pkg::OP_RDSR1, 8'h00, 1'b0); while (r[0] !== 1'b0);
    check(r & 32'h0000_00FF, {24'h0, v[7:2], 2'b00});
    rd(sfc_pkg::OP_RDSR2, 8'h00, 1'b1);
    tend(4);
    wrs(sfc_pkg::OP_VWREN, w[7:0]);
    rd(sfc_pkg::OP_RDSR1, {w[7:2], 2'b00}, 1'b1);
    tend(5);
    rd(sfc_pkg::OP_RPD_ID, PART, 1'b1);
    tend(6);
    presetn <= 1'b0;
    pwr_n <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    pwr_n <= 1'b1;
    @(posedge pclk);
    rd(sfc_pkg::OP_RDSR1, 8'h00, 1'b0);
    check(r & 32'h0000_00FF, {24'h0, v[7:2], 2'b00});
    tend(7);
    apb(1'b0, 8'h20, 32'h0000_0000);
    check({31'h0, last_err}, 32'h1);
    tend(8);
    wrap_up;
  end
endmodule
